/* File: verification/flash_seq_monitor.sv */
// Purpose: port checks on the flash self-programming sequencer
// Assumes: strobe lengths handed on as parameters
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module flash_seq_monitor
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned PROG_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cpu_stall,
  input wire logic flash_erase_en,
  input wire logic flash_prog_en,
  input wire logic [EA_W-1:0] flash_addr,
  input wire logic op_done
);
  logic [31:0] len_q;
  logic [31:0] len_d;
  // strobe run length, held until the stall drops
  always_comb begin
    len_d = len_q;
    if (flash_erase_en || flash_prog_en) len_d = len_q + 32'h1;
    else if (!cpu_stall) len_d = 32'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) len_q <= 32'h0;
    else len_q <= len_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_STALL_COVERS: assert property ((flash_erase_en || flash_prog_en) |-> cpu_stall)
    else $error("strobe active without stall");
  AST_STALL_START: assert property ($rose(cpu_stall) |=> (flash_erase_en ^ flash_prog_en))
    else $error("no single strobe after stall rose");
  AST_ONE_STROBE: assert property (!(flash_erase_en && flash_prog_en))
    else $error("erase and program strobes together");
  // done lands two cycles after the last strobe cycle, together with the stall release
  AST_ERASE_LEN: assert property (op_done && $past(flash_erase_en, 2) |-> len_q == ERASE_CYCLES)
    else $error("erase strobe length wrong");
  AST_PROG_LEN: assert property (op_done && $past(flash_prog_en, 2) |-> len_q == PROG_CYCLES)
    else $error("program strobe length wrong");
  AST_DONE_END: assert property (op_done |-> !cpu_stall && $past(cpu_stall) && !flash_erase_en && !flash_prog_en)
    else $error("stall not released with done");
  AST_DONE_PULSE: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
  AST_ADDR_HELD: assert property (cpu_stall && $past(cpu_stall) |-> $stable(flash_addr))
    else $error("target moved during operation");
  AST_PROG_ALIGN: assert property ($rose(flash_prog_en) |-> flash_addr[1:0] == PROG_ALIGN)
    else $error("program on unaligned target");
endmodule : flash_seq_monitor

/* File: verification/self_program_flash_sequencer_tb.sv */
// Purpose: self-checking bench for the flash self-programming sequencer
// Assumes: short strobe counts so an operation takes a few dozen cycles
// Notes: AHB-Lite master tasks, random targets from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module self_program_flash_sequencer_tb;
  import flash_seq_pkg::*;
  localparam int unsigned ERASE_N = 20;
  localparam int unsigned PROG_N = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cpu_stall, flash_erase_en, flash_prog_en, op_done;
  logic [EA_W-1:0] flash_addr;
  logic [WORD_W-1:0] flash_wdata_lo, flash_wdata_hi;
  logic [31:0] rd;
  logic [23:0] t;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  self_program_flash_sequencer #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_stall(cpu_stall), .flash_erase_en(flash_erase_en),
    .flash_prog_en(flash_prog_en), .flash_addr(flash_addr), .flash_wdata_lo(flash_wdata_lo),
    .flash_wdata_hi(flash_wdata_hi), .op_done(op_done));

  // 125 MHz clock
  initial begin
    forever #4 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // one single AHB transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  // whether a start is taken: proper unlock, and program targets on the pair boundary
  function automatic logic exp_go(input int mode, input logic prog, input logic [23:0] tgt);
    return (mode == 0) && (!prog || tgt[1:0] == PROG_ALIGN);
  endfunction : exp_go

  // edges from the start write to the done pulse: strobe run, timer done flop, done output flop
  function automatic int exp_len(input logic prog);
    return int'(prog ? PROG_N + 2 : ERASE_N + 2);
  endfunction : exp_len

  // load target, unlock (mode 0 proper, 1 stray write, 2 wrong key), start
  task automatic run_op(input int mode, input logic prog, input logic [23:0] tgt);
    logic [23:0] lo;
    logic [23:0] hi;
    logic go;
    int n;
    lo = 24'($urandom);
    hi = 24'($urandom);
    go = exp_go(mode, prog, tgt);
    bus(1'b1, ADDR_HIGH_OFS, {24'h000000, tgt[23:16]});
    bus(1'b1, ADDR_LOW_OFS, {16'h0000, tgt[15:0]});
    bus(1'b1, DATA_LO_OFS, {8'h00, lo});
    bus(1'b1, DATA_HI_OFS, {8'h00, hi});
    bus(1'b1, KEY_OFS, 32'h00000055);
    if (mode == 1) bus(1'b1, ADDR_LOW_OFS, {16'h0000, tgt[15:0]});
    bus(1'b1, KEY_OFS, (mode == 2) ? 32'h0000005A : 32'h000000AA);
    bus(1'b1, CTRL_OFS, 32'h00008000 | {31'h0, prog});
    #1;
    `CHK("stall", go, cpu_stall)
    if (go) begin
      `CHK("target", tgt, flash_addr)
      if (prog) `CHK("pair", {hi, lo}, {flash_wdata_hi, flash_wdata_lo})
      n = 0;
      while (op_done !== 1'b1 && n < 100) begin
        @(posedge hclk);
        #1;
        n++;
        if (n == 1) `CHK("strobe", {prog, !prog}, {flash_prog_en, flash_erase_en})
      end
      `CHK("length", exp_len(prog), n)
      @(posedge hclk);
      #1;
      `CHK("stall end", 1'b0, cpu_stall)
    end
    repeat (2) @(posedge hclk); // two quiet slots after a start
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", go ? 32'h0 : 32'h00002000, rd & 32'h0000A000)
    bus(1'b1, CTRL_OFS, 32'h00002000);
  endtask : run_op

  // main sequence
  initial begin
    void'($urandom(85519));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK("reset", 6'b100000, {hreadyout, hresp, cpu_stall, flash_erase_en, flash_prog_en, op_done})
    @(posedge hclk);
    bus(1'b1, KEY_OFS, 32'h00000055);
    bus(1'b0, KEY_OFS, 32'h0);
    `CHK("key read", 32'h0, rd)
    bus(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    run_op(0, 1'b0, 24'hFFFFFE); // erase the top page first
    run_op(0, 1'b1, 24'hFFFFFE);
    // erase and program, aligned and not, then broken unlocks
    for (int i = 0; i < 8; i++) begin
      if (!i[0]) t = 24'($urandom); // each program follows the erase of its page
      t[1:0] = (i < 4 || i > 5) ? PROG_ALIGN : 2'h1;
      run_op(i > 5 ? i - 5 : 0, i[0], t);
    end
    bus(1'b1, CTRL_OFS, 32'h00008000);
    #1;
    `CHK("restart", 1'b0, cpu_stall)
    print_verdict();
  end
endmodule : self_program_flash_sequencer_tb

bind self_program_flash_sequencer flash_seq_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon_u (
  .hclk(hclk), .hresetn(hresetn), .cpu_stall(cpu_stall), .flash_erase_en(flash_erase_en),
  .flash_prog_en(flash_prog_en), .flash_addr(flash_addr), .op_done(op_done));

/* File: verilog/flash_op_timer.sv */
// Purpose: drives the flash array strobes for the length of one operation
// Assumes: launch is a one-cycle pulse that only comes while idle
// Notes: done pulses once in the cycle after the last strobe cycle
`timescale 1ns/1ps
module flash_op_timer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT,
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic launch,
  input wire logic is_prog,
  output logic erase_en,
  output logic prog_en,
  output logic done
);

  tim_state_t state_q, state_d;
  logic [31:0] count_q, count_d;
  logic erase_en_q, erase_en_d;
  logic prog_en_q, prog_en_d;
  logic done_q, done_d;

  // next state of the operation timer
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    erase_en_d = erase_en_q;
    prog_en_d = prog_en_q;
    done_d = 1'b0;
    unique case (state_q)
      TIM_IDLE: begin
        if (launch) begin
          state_d = TIM_RUN;
          count_d = is_prog ? 32'(PROG_CYCLES - 1) : 32'(ERASE_CYCLES - 1);
          erase_en_d = ~is_prog;
          prog_en_d = is_prog;
        end
      end
      TIM_RUN: begin
        if (count_q == 32'h00000000) begin
          state_d = TIM_IDLE;
          erase_en_d = 1'b0;
          prog_en_d = 1'b0;
          done_d = 1'b1;
        end else begin
          count_d = count_q - 32'h00000001;
        end
      end
    endcase
  end

  // timer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= TIM_IDLE;
      count_q <= 32'h00000000;
      erase_en_q <= 1'b0;
      prog_en_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      erase_en_q <= erase_en_d;
      prog_en_q <= prog_en_d;
      done_q <= done_d;
    end
  end

  assign erase_en = erase_en_q;
  assign prog_en = prog_en_q;
  assign done = done_q;

endmodule : flash_op_timer

/* File: verilog/flash_seq_pkg.sv */
// Purpose: shared constants and types for the flash self-programming sequencer
// Assumes: 125 MHz hclk, AHB-Lite register access with 32-bit words
// Notes: times are kept in their own unit; cycle counts are derived from them
package flash_seq_pkg;

  // clock and operation timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ERASE_TIME_US = 20000; // page erase time, plain default
  localparam int unsigned PROG_TIME_US = 50; // word pair write time, plain default
  // least times round up to whole cycles
  localparam int unsigned ERASE_CYCLES_DFLT = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYCLES_DFLT = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets within the block window
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] KEY_OFS = 8'h04;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h08;
  localparam logic [7:0] ADDR_LOW_OFS = 8'h0C;
  localparam logic [7:0] DATA_LO_OFS = 8'h10;
  localparam logic [7:0] DATA_HI_OFS = 8'h14;

  // control register fields
  localparam int unsigned CTRL_START_BIT = 15;
  localparam int unsigned CTRL_ERR_BIT = 13;
  localparam int unsigned CTRL_OP_BIT = 0; // 1 = program pair, 0 = erase page

  // widths
  localparam int unsigned ADDR_HIGH_W = 8;
  localparam int unsigned ADDR_LOW_W = 16;
  localparam int unsigned EA_W = 24;
  localparam int unsigned WORD_W = 24;

  // unlock key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // program target must sit on addresses 0x2, 0x6, 0xA, ...
  localparam logic [1:0] PROG_ALIGN = 2'h2;

  // values after reset
  localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RST = 8'h00;
  localparam logic [ADDR_LOW_W-1:0] ADDR_LOW_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

  // decoded register selector
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_KEY = 3'b010,
    SEL_ADDR_HIGH = 3'b011,
    SEL_ADDR_LOW = 3'b100,
    SEL_DATA_LO = 3'b101,
    SEL_DATA_HI = 3'b110
  } reg_sel_t;

  // unlock sequence progress
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;

  // operation timer state
  typedef enum logic {
    TIM_IDLE = 1'b0,
    TIM_RUN = 1'b1
  } tim_state_t;

endpackage : flash_seq_pkg

/* File: verilog/self_program_flash_sequencer.sv */
// Purpose: run-time self programming sequencer for on-chip program flash
// Assumes: AHB-Lite slave, single word transfers, one master
// Notes: writes take no wait state, reads take one wait state
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

module self_program_flash_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DFLT,
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic cpu_stall,
  output logic flash_erase_en,
  output logic flash_prog_en,
  output logic [EA_W-1:0] flash_addr,
  output logic [WORD_W-1:0] flash_wdata_lo,
  output logic [WORD_W-1:0] flash_wdata_hi,
  output logic op_done
);

  // decode of a byte offset into a register selector
  function automatic reg_sel_t decode_sel(input logic [31:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    // anything above the register window decodes to no register
    if (a[31:8] == 24'h000000) begin
      unique case (a[7:0])
        CTRL_OFS: s = SEL_CTRL;
        KEY_OFS: s = SEL_KEY;
        ADDR_HIGH_OFS: s = SEL_ADDR_HIGH;
        ADDR_LOW_OFS: s = SEL_ADDR_LOW;
        DATA_LO_OFS: s = SEL_DATA_LO;
        DATA_HI_OFS: s = SEL_DATA_HI;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode_sel

  // bus state
  logic wr_pend_q, wr_pend_d;
  reg_sel_t wr_sel_q, wr_sel_d;
  logic rd_pend_q, rd_pend_d;
  reg_sel_t rd_sel_q, rd_sel_d;
  logic hreadyout_q, hreadyout_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic addr_phase;

  // register and sequencing state
  logic [ADDR_HIGH_W-1:0] addr_high_q, addr_high_d;
  logic [ADDR_LOW_W-1:0] addr_low_q, addr_low_d;
  logic [WORD_W-1:0] data_lo_q, data_lo_d;
  logic [WORD_W-1:0] data_hi_q, data_hi_d;
  logic op_prog_q, op_prog_d;
  logic start_q, start_d;
  logic err_q, err_d;
  key_state_t key_q, key_d;
  logic [EA_W-1:0] tgt_addr_q, tgt_addr_d;
  logic [WORD_W-1:0] tgt_lo_q, tgt_lo_d;
  logic [WORD_W-1:0] tgt_hi_q, tgt_hi_d;
  // operation control flags
  logic stall_q, stall_d;
  logic launch_q, launch_d;
  logic done_q, done_d;
  // timer hand-off and derived address
  logic [EA_W-1:0] eff_addr;
  logic tim_done;
  logic tim_erase_en;
  logic tim_prog_en;

  // address phase accepted when selected and a transfer is under way
  assign addr_phase = hsel && htrans[1] && hready;

  // effective address from the two address registers
  assign eff_addr = {addr_high_q, addr_low_q};

  // next state of the bus slave
  always_comb begin
    wr_pend_d = 1'b0;
    wr_sel_d = wr_sel_q;
    rd_pend_d = 1'b0;
    rd_sel_d = rd_sel_q;
    hreadyout_d = 1'b1;
    hrdata_d = hrdata_q;
    // writes land next cycle, reads wait one cycle
    if (addr_phase && hwrite) begin
      wr_pend_d = 1'b1;
      wr_sel_d = decode_sel(haddr);
    end else if (addr_phase) begin
      rd_pend_d = 1'b1;
      rd_sel_d = decode_sel(haddr);
      hreadyout_d = 1'b0; // one wait state so reads see finished writes
    end
    // read data mux, unused upper bits read zero
    if (rd_pend_q) begin
      hrdata_d = RDATA_RST;
      unique case (rd_sel_q)
        SEL_CTRL: begin
          hrdata_d[CTRL_START_BIT] = start_q;
          hrdata_d[CTRL_ERR_BIT] = err_q;
          hrdata_d[CTRL_OP_BIT] = op_prog_q;
        end
        SEL_KEY: hrdata_d = RDATA_RST;
        SEL_ADDR_HIGH: hrdata_d[ADDR_HIGH_W-1:0] = addr_high_q;
        SEL_ADDR_LOW: hrdata_d[ADDR_LOW_W-1:0] = addr_low_q;
        SEL_DATA_LO: hrdata_d[WORD_W-1:0] = data_lo_q;
        SEL_DATA_HI: hrdata_d[WORD_W-1:0] = data_hi_q;
        SEL_NONE: hrdata_d = RDATA_RST;
      endcase
    end
  end

  // bus slave registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // idle bus: ready high, no transfer pending
      wr_pend_q <= 1'b0;
      wr_sel_q <= SEL_NONE;
      rd_pend_q <= 1'b0;
      rd_sel_q <= SEL_NONE;
      hreadyout_q <= 1'b1;
      hrdata_q <= RDATA_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_sel_q <= wr_sel_d;
      rd_pend_q <= rd_pend_d;
      rd_sel_q <= rd_sel_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
    end
  end

  // next state of registers, unlock sequence and operation launch
  always_comb begin
    addr_high_d = addr_high_q;
    addr_low_d = addr_low_q;
    data_lo_d = data_lo_q;
    data_hi_d = data_hi_q;
    op_prog_d = op_prog_q;
    start_d = start_q;
    err_d = err_q;
    key_d = key_q;
    tgt_addr_d = tgt_addr_q;
    tgt_lo_d = tgt_lo_q;
    tgt_hi_d = tgt_hi_q;
    stall_d = stall_q;
    launch_d = 1'b0;
    // done pulse one cycle behind the timer, lands with the stall release
    done_d = tim_done;
    // operation end drops the start flag and releases the processor
    if (tim_done) begin
      start_d = 1'b0;
      stall_d = 1'b0;
    end
    // register writes take effect at the end of their data phase
    if (wr_pend_q) begin
      // any write other than the expected next key step cancels the unlock
      key_d = KEY_IDLE;
      unique case (wr_sel_q)
        // unlock key steps
        SEL_KEY: begin
          if (hwdata[7:0] == KEY_FIRST) begin
            key_d = KEY_GOT_FIRST;
          end else if (key_q == KEY_GOT_FIRST && hwdata[7:0] == KEY_SECOND) begin
            key_d = KEY_ARMED;
          end
        end
        // control: error clear, op select and start
        SEL_CTRL: begin
          if (hwdata[CTRL_ERR_BIT]) begin
            err_d = 1'b0; // write one to clear, a refused start below wins
          end
          if (!start_q) begin
            op_prog_d = hwdata[CTRL_OP_BIT];
            if (hwdata[CTRL_START_BIT]) begin
              if (key_q != KEY_ARMED) begin
                err_d = 1'b1;
              end else if (hwdata[CTRL_OP_BIT] && eff_addr[1:0] != PROG_ALIGN) begin
                err_d = 1'b1;
              end else begin
                start_d = 1'b1;
                stall_d = 1'b1;
                launch_d = 1'b1;
                tgt_addr_d = eff_addr;
                tgt_lo_d = data_lo_q;
                tgt_hi_d = data_hi_q;
              end
            end
          end
        end
        // target and data registers frozen while busy
        SEL_ADDR_HIGH: begin
          if (!start_q) begin
            addr_high_d = hwdata[ADDR_HIGH_W-1:0];
          end
        end
        SEL_ADDR_LOW: begin
          if (!start_q) begin
            addr_low_d = hwdata[ADDR_LOW_W-1:0];
          end
        end
        SEL_DATA_LO: begin
          if (!start_q) begin
            data_lo_d = hwdata[WORD_W-1:0];
          end
        end
        SEL_DATA_HI: begin
          if (!start_q) begin
            data_hi_d = hwdata[WORD_W-1:0];
          end
        end
        SEL_NONE: begin
          data_lo_d = data_lo_q;
        end
      endcase
    end
  end

  // register file and sequencing registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // nothing armed and no operation after reset
      addr_high_q <= ADDR_HIGH_RST;
      addr_low_q <= ADDR_LOW_RST;
      data_lo_q <= WORD_RST;
      data_hi_q <= WORD_RST;
      op_prog_q <= 1'b0;
      start_q <= 1'b0;
      err_q <= 1'b0;
      key_q <= KEY_IDLE;
      tgt_addr_q <= {EA_W{1'b0}};
      tgt_lo_q <= WORD_RST;
      tgt_hi_q <= WORD_RST;
      stall_q <= 1'b0;
      launch_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      addr_high_q <= addr_high_d;
      addr_low_q <= addr_low_d;
      data_lo_q <= data_lo_d;
      data_hi_q <= data_hi_d;
      op_prog_q <= op_prog_d;
      start_q <= start_d;
      err_q <= err_d;
      key_q <= key_d;
      // captured target stands for the whole operation
      tgt_addr_q <= tgt_addr_d;
      tgt_lo_q <= tgt_lo_d;
      tgt_hi_q <= tgt_hi_d;
      stall_q <= stall_d;
      launch_q <= launch_d;
      done_q <= done_d;
    end
  end

  // strobe timing for the flash array
  flash_op_timer #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .launch(launch_q),
    .is_prog(op_prog_q),
    .erase_en(tim_erase_en),
    .prog_en(tim_prog_en),
    .done(tim_done)
  );

  // outputs straight from flip-flops, except hresp, which is tied to OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0; // always OKAY
  assign cpu_stall = stall_q;
  // flash array side
  assign flash_erase_en = tim_erase_en;
  assign flash_prog_en = tim_prog_en;
  assign flash_addr = tgt_addr_q;
  assign flash_wdata_lo = tgt_lo_q;
  assign flash_wdata_hi = tgt_hi_q;
  assign op_done = done_q;

endmodule : self_program_flash_sequencer
